// ===== core/adc_ctl_pkg.sv
/*
 * constants, field layout and state type of the converter's serial control front end.
 * assumes a 200 mhz ref_clk and that the analog side is a separate block.
 */
// Operation
// RL1 - eight-bit control word shifted in serially
// RL2 - msb first, bit taken on io clock rise
// RL3 - d7..d4 choose channel, test voltage, power-down
// RL4 - 0-10 channels, 11-13 test levels, 14 off
// RL5 - address serves the conversion after this cycle
// RL6 - length field sets this cycle's clock count
// RL7 - 00/10: twelve clocks, convert after twelfth fall
// RL8 - 11: sixteen clocks, four zero pad bits
// RL9 - 01: eight clocks, four low bits dropped
// RL10 - host gives exactly the selected clock count
// RL11 - new length acts after six rising edges
// RL12 - length change corrupts one lsb-first result
// RL13 - sampling begins on fourth falling edge
// RL14 - sampling lasts until last falling edge
// RL15 - eoc falls fixed delay after last fall
// RL16 - host holds data input steady until eoc
// RL17 - host should prefer twelve-bit length
// RL18 - data input ignored after eight clocks
// RL19 - address 1110 powers down at fourth fall
// RL20 - d1 bit order, from next cycle on
// RL21 - d0 signed format inverts msb, this conversion
package adc_ctl_pkg;
    localparam int         CTL_W       = 8;
    localparam int         CONV_W      = 12;
    localparam int         OUT_W       = 16;
    localparam int         FIFO_DEPTH  = 16;
    // control word field positions
    localparam int         ADDR_MSB    = 7;
    localparam int         ADDR_LSB    = 4;
    localparam int         LEN_HI_BIT  = 3;
    localparam int         LEN_LO_BIT  = 2;
    localparam int         LOW_FIRST_BIT = 1;
    localparam int         SIGNED_BIT    = 0;
    localparam logic [7:0] CTL_RESET   = 8'h00;
    // address codes
    localparam logic [3:0] ADDR_LAST_CH = 4'ha;
    localparam logic [3:0] ADDR_HALF    = 4'hb;
    localparam logic [3:0] ADDR_LOW     = 4'hc;
    localparam logic [3:0] ADDR_HIGH    = 4'hd;
    localparam logic [3:0] ADDR_PDOWN   = 4'he;
    // length field codes and clock counts
    localparam logic [1:0] LEN_CODE_8  = 2'h1;
    localparam logic [1:0] LEN_CODE_16 = 2'h3;
    localparam logic [4:0] LEN_8       = 5'h08;
    localparam logic [4:0] LEN_12      = 5'h0c;
    localparam logic [4:0] LEN_16      = 5'h10;
    localparam logic [3:0] CTL_BITS    = 4'h8;
    localparam logic [4:0] SAMPLE_FALL = 5'h04;
    localparam int         PAD_BITS    = 4;
    // fixed delay from last falling io clock edge to eoc low
    localparam int         CLK_PERIOD_PS = 5000;
    localparam int         EOC_DELAY_NS  = 100;
    localparam int         EOC_DLY_CYC   = (EOC_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [7:0] EOC_DLY_LAST  = 8'(EOC_DLY_CYC - 1);

    typedef enum logic [1:0] {ST_OFF, ST_IO, ST_DLY, ST_CONV} frame_e;
endpackage

// ===== core/ctl_stream_if.sv
/*
 * valid/ready word carrier between the result fifo and the frame logic.
 * assumes both ends sit on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none
interface ctl_stream_if #(parameter int W = 12);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ===== core/word_fifo.sv
/*
 * flip-flop fifo with valid/ready on both sides.
 * assumes a synchronous active-high reset on the same clock as both sides.
 */
`timescale 1ns/10ps
`default_nettype none
module word_fifo #(
    parameter int W     = 12,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rst,
    // filling side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // draining side
    ctl_stream_if.src         out
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0]   count;
    wire           push = in_valid && in_ready;
    wire           pop  = out.valid && out.ready;

    // full and empty come straight from the count so back-pressure is exact
    assign in_ready  = (count != (AW+1)'(DEPTH));
    assign out.valid = (count != '0);
    assign out.data  = mem[rd_ptr];

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            wr_ptr <= push ? AW'((wr_ptr + 1'b1) % DEPTH) : wr_ptr;
            rd_ptr <= pop ? AW'((rd_ptr + 1'b1) % DEPTH) : rd_ptr;
            count  <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

// ===== core/adc_serial_control_frame.sv
/*
 * serial control front end: control word capture, i/o cycle framing,
 * sampling window, eoc timing and the result shift-out.
 * assumes the converter proper pushes 12-bit results into res_* and
 * starts on conv_start; the io clock, data input and chip select are pins.
 */
`timescale 1ns/10ps
`default_nettype none
module adc_serial_control_frame #(
    parameter int FIFO_DEPTH = adc_ctl_pkg::FIFO_DEPTH
) (
    // clock and reset
    input  wire logic                            ref_clk,
    input  wire logic                            rst,
    // serial pins from the host
    input  wire logic                            io_clk,
    input  wire logic                            data_in,
    input  wire logic                            cs_n,
    // serial pins to the host
    output logic                                 data_out,
    output logic                                 data_out_oe,
    output logic                                 eoc,
    // converter control
    output logic                                 conv_start,
    output logic                                 sample_active,
    output logic                                 power_down,
    output logic [3:0]                           conv_sel,
    output logic                                 conv_sel_ext,
    output logic [1:0]                           conv_test_sel,
    // results from the converter
    input  wire logic                            res_valid,
    output logic                                 res_ready,
    input  wire logic [adc_ctl_pkg::CONV_W-1:0]  res_data
);
    import adc_ctl_pkg::*;

    // eoc is a flop, so its fall is sampled one edge after the count ends
    localparam int EOC_WAIT = EOC_DLY_CYC + 1;

    ctl_stream_if #(.W(CONV_W)) res_if ();

    word_fifo #(
        .W     (CONV_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .in_valid (res_valid),
        .in_ready (res_ready),
        .in_data  (res_data),
        .out      (res_if.src)
    );

    // three-stage pin synchronisers, a level counts once stages two and three agree
    logic [2:0] clk_sy;
    logic [2:0] din_sy;
    logic [2:0] cs_sy;
    logic       io_lvl;
    logic       cs_lvl;
    always_ff @(posedge ref_clk) begin
        clk_sy <= {clk_sy[1:0], io_clk};
        din_sy <= {din_sy[1:0], data_in};
        cs_sy  <= {cs_sy[1:0], cs_n};
    end

    wire clk_stable = (clk_sy[1] == clk_sy[2]);
    wire cs_stable  = (cs_sy[1] == cs_sy[2]);
    wire rise_raw   = clk_stable && clk_sy[2] && !io_lvl;
    wire fall_raw   = clk_stable && !clk_sy[2] && io_lvl;
    wire cs_fall    = cs_stable && !cs_sy[2] && cs_lvl;
    wire cs_rise    = cs_stable && cs_sy[2] && !cs_lvl;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            io_lvl <= 1'b0;
            cs_lvl <= 1'b1;
        end else begin
            io_lvl <= clk_stable ? clk_sy[2] : io_lvl;
            cs_lvl <= cs_stable ? cs_sy[2] : cs_lvl;
        end
    end

    // frame state
    frame_e     state;
    logic [7:0] ctl;
    logic [3:0] rise_cnt;
    logic [4:0] fall_cnt;
    logic [7:0] dly_cnt;
    logic [OUT_W-1:0] out_word;
    logic       out_low_first;
    logic       conv_signed;
    logic [4:0] prev_len;

    // io clock edges only count inside an i/o cycle with chip select low
    wire in_io    = (state == ST_IO) && !cs_lvl;
    wire rise_evt = in_io && rise_raw;
    wire fall_evt = in_io && fall_raw;

    // decode of the word being received
    wire [3:0] addr     = ctl[ADDR_MSB:ADDR_LSB];                  // RL3
    wire [1:0] len_code = {ctl[LEN_HI_BIT], ctl[LEN_LO_BIT]};
    wire       addr_pd  = (addr == ADDR_PDOWN);                    // RL19
    // at the fourth fall only four bits are in, still at the bottom of the word
    wire       head_pd  = (ctl[ADDR_MSB-ADDR_LSB:0] == ADDR_PDOWN); // RL19
    // length is read from the live word; it is whole by the eighth fall, the earliest end
    wire [4:0] cycle_len = (len_code == LEN_CODE_8)  ? LEN_8  :    // RL9 RL11
                           (len_code == LEN_CODE_16) ? LEN_16 :    // RL8
                                                       LEN_12;     // RL7 RL6
    wire [4:0] fall_next = fall_cnt + 5'h01;
    wire       take_bit  = rise_evt && (rise_cnt < CTL_BITS);      // RL18
    wire       hit_samp  = fall_evt && (fall_next == SAMPLE_FALL); // RL13
    wire       last_fall = fall_evt && (fall_next == cycle_len);   // RL14
    wire       dly_done  = (state == ST_DLY) && (dly_cnt == EOC_DLY_LAST);
    wire       res_pop   = (state == ST_CONV) && res_if.valid;
    wire       new_cycle = cs_fall || res_pop || (last_fall && addr_pd);

    // converter waits in the fifo until a conversion is pending, so it back-pressures
    assign res_if.ready = (state == ST_CONV);

    // channel decode for the converter's input multiplexer
    assign conv_sel_ext  = (conv_sel <= ADDR_LAST_CH);              // RL4
    assign conv_test_sel = (conv_sel == ADDR_HALF) ? 2'h1 :         // RL4
                           (conv_sel == ADDR_LOW)  ? 2'h2 :
                           (conv_sel == ADDR_HIGH) ? 2'h3 : 2'h0;

    // output bit pick: lsb first starts at the pad end of the previous length
    wire [4:0] lsb_idx  = (5'(OUT_W) - prev_len) + fall_cnt;        // RL12
    wire [4:0] msb_idx  = 5'(OUT_W - 1) - fall_cnt;
    wire [4:0] out_idx  = out_low_first ? lsb_idx : msb_idx;
    wire       out_bit  = (out_idx < 5'(OUT_W)) ? out_word[out_idx[3:0]] : 1'b0;
    // signed result is the unsigned one with its msb turned over
    wire [CONV_W-1:0] fmt_res = res_if.data ^ {conv_signed, {(CONV_W-1){1'b0}}}; // RL21

    // frame sequencer
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state <= ST_OFF;
        end else if (cs_rise) begin
            state <= ST_OFF;
        end else begin
            unique case (state)
                ST_OFF:  state <= cs_fall ? ST_IO : ST_OFF;
                ST_IO:   state <= (last_fall && !addr_pd) ? ST_DLY : ST_IO;   // RL7 RL8 RL9
                ST_DLY:  state <= dly_done ? ST_CONV : ST_DLY;
                ST_CONV: state <= res_pop ? ST_IO : ST_CONV;
            endcase
        end
    end

    // bit counters restart with every i/o cycle
    always_ff @(posedge ref_clk) begin
        if (rst || new_cycle) begin
            rise_cnt <= 4'h0;
            fall_cnt <= 5'h00;
        end else begin
            rise_cnt <= (rise_evt && rise_cnt < CTL_BITS) ? rise_cnt + 4'h1 : rise_cnt;
            fall_cnt <= fall_evt ? fall_next : fall_cnt;
        end
    end

    // control word shifts in msb first, later bits of long cycles are dropped
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctl <= CTL_RESET;                                          // RL1
        end else if (take_bit) begin
            ctl <= {ctl[CTL_W-2:0], din_sy[2]};                        // RL2
        end
    end

    // eoc delay is counted in ref_clk so the sample instant never jitters
    always_ff @(posedge ref_clk) begin
        if (rst || state != ST_DLY) begin
            dly_cnt <= 8'h00;
        end else begin
            dly_cnt <= dly_cnt + 8'h01;
        end
    end

    // sampling window and power-down
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sample_active <= 1'b0;
            power_down    <= 1'b1;        // converter starts powered down
        end else if (cs_rise || last_fall) begin
            sample_active <= 1'b0;                                     // RL14
        end else if (hit_samp) begin
            sample_active <= !head_pd;                                 // RL13
            power_down    <= head_pd;                                  // RL19
        end
    end

    // settings handed on at the end of the cycle
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            conv_sel <= 4'h0;
            conv_signed   <= 1'b0;
            out_low_first <= 1'b0;
            prev_len <= LEN_12;
        end else if (last_fall) begin
            conv_sel <= addr;                                          // RL5
            conv_signed   <= ctl[SIGNED_BIT];                          // RL21
            out_low_first <= ctl[LOW_FIRST_BIT];                       // RL20
            prev_len <= cycle_len;
        end
    end

    // eoc and the conversion start strobe
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            eoc        <= 1'b1;
            conv_start <= 1'b0;
        end else begin
            conv_start <= dly_done;
            eoc        <= (dly_done || (state == ST_CONV && !res_pop)) ? 1'b0 : 1'b1; // RL15
        end
    end

    // result register: 12-bit result msb-justified with zero pad bits below
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            out_word <= '0;
        end else if (res_pop) begin
            out_word <= {fmt_res, {PAD_BITS{1'b0}}};                   // RL8 RL9
        end
    end

    // serial output, forced low while a conversion runs, released with chip select
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            data_out    <= 1'b0;
            data_out_oe <= 1'b0;
        end else begin
            data_out    <= (state == ST_IO) ? out_bit : 1'b0;
            data_out_oe <= !cs_lvl;
        end
    end

    // checks
    sequence s_end_cycle;
        last_fall && !addr_pd;
    endsequence

    sequence s_eoc_fall;
        ##(EOC_WAIT) !eoc && conv_start;
    endsequence

    property p_eoc_delay;
        @(posedge ref_clk) disable iff (rst || cs_rise) s_end_cycle |-> eoc ##0 s_eoc_fall;
    endproperty
    a_eoc_delay: assert property (p_eoc_delay) else $error("eoc not low after fixed delay"); // RL15

    property p_sample_start;
        @(posedge ref_clk) disable iff (rst) hit_samp && !head_pd |=> sample_active;
    endproperty
    a_sample_start: assert property (p_sample_start) else $error("sampling not started"); // RL13

    property p_pdown;
        @(posedge ref_clk) disable iff (rst) hit_samp && head_pd |=> power_down && !sample_active;
    endproperty
    a_pdown: assert property (p_pdown) else $error("power-down not taken"); // RL19

    property p_ignore_late;
        @(posedge ref_clk) disable iff (rst) rise_evt && rise_cnt == CTL_BITS |=> $stable(ctl);
    endproperty
    a_ignore_late: assert property (p_ignore_late) else $error("late data bit changed word"); // RL18

    property p_shift_msb_first;
        @(posedge ref_clk) disable iff (rst) take_bit |=> ctl[0] == $past(din_sy[2]);
    endproperty
    a_shift_msb_first: assert property (p_shift_msb_first) else $error("bit not shifted in"); // RL2

    property p_len12_end;
        @(posedge ref_clk) disable iff (rst)
            fall_evt && fall_next == LEN_12 && len_code[0] == 1'b0 && !addr_pd
            |=> !sample_active && state == ST_DLY;
    endproperty
    a_len12_end: assert property (p_len12_end) else $error("12-clock cycle end missed"); // RL7

    property p_len8_end;
        @(posedge ref_clk) disable iff (rst)
            fall_evt && fall_next == LEN_8 && len_code == LEN_CODE_8 && !addr_pd
            |=> state == ST_DLY;
    endproperty
    a_len8_end: assert property (p_len8_end) else $error("8-clock cycle end missed"); // RL9

    property p_len16_hold;
        @(posedge ref_clk) disable iff (rst)
            fall_evt && fall_next == LEN_12 && len_code == LEN_CODE_16 |=> state == ST_IO;
    endproperty
    a_len16_hold: assert property (p_len16_hold) else $error("16-clock cycle ended early"); // RL8

    property p_addr_next;
        @(posedge ref_clk) disable iff (rst) last_fall |=> conv_sel == $past(addr);
    endproperty
    a_addr_next: assert property (p_addr_next) else $error("address not handed on"); // RL5

    property p_signed_msb;
        @(posedge ref_clk) disable iff (rst)
            res_pop |=> out_word[OUT_W-1] == ($past(res_if.data[CONV_W-1]) ^ conv_signed)
                        && out_word[PAD_BITS-1:0] == '0;
    endproperty
    a_signed_msb: assert property (p_signed_msb) else $error("result format wrong"); // RL21

    property p_order_next;
        @(posedge ref_clk) disable iff (rst)
            last_fall |=> out_low_first == $past(ctl[LOW_FIRST_BIT]);
    endproperty
    a_order_next: assert property (p_order_next) else $error("order not handed on"); // RL20

    property p_start_single;
        @(posedge ref_clk) disable iff (rst) conv_start |-> !eoc ##1 !conv_start;
    endproperty
    a_start_single: assert property (p_start_single) else $error("start strobe wrong"); // RL15
endmodule
`default_nettype wire

// ===== test/host_port_model.sv
/*
 * host serial port model: drives chip select, io clock and data input.
 * assumes the caller starts each frame at a falling ref_clk edge.
 */
`timescale 1ns/10ps
`default_nettype none
module host_port_model (
    // clock
    input  wire logic ref_clk,
    // pins to the device
    output logic      io_clk,
    output logic      data_in,
    output logic      cs_n,
    // pins from the device
    input  wire logic data_out,
    input  wire logic data_out_oe,
    input  wire logic sample_active
);
    // a released line reads as the opposite of the last driven bit
    wire line_bit = data_out_oe ? data_out : ~data_out;

    // idle pins: clock parked low, device deselected
    initial begin
        io_clk  = 1'b0;
        data_in = 1'b0;
        cs_n    = 1'b1;
    end

    // one i/o cycle of n clocks; stop below n drops chip select early
    task automatic frame(input logic [7:0] w, input int n, input int stop,
                         output logic [15:0] got, output logic [15:0] smp);
        int i;
        got = 16'h0000;
        smp = 16'h0000;
        @(negedge ref_clk);
        if (cs_n) begin
            cs_n = 1'b0;
            repeat (10) @(negedge ref_clk); // clock kept low while select settles
        end
        for (i = 0; i < n; i++) begin
            if (i == stop) begin
                cs_n = 1'b1;
                return;
            end
            // after d0 the line is left steady so sampling stays quiet
            if (i < 8)
                data_in = w[7 - i];
            repeat (12) @(negedge ref_clk);
            got = {got[14:0], line_bit};
            smp = {smp[14:0], sample_active};
            io_clk = 1'b1;
            repeat (13) @(negedge ref_clk);
            io_clk = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// ===== test/test_adc_serial_control_frame.sv
/*
 * self-checking bench of the serial control front end.
 * assumes the host model above and a bench-driven converter result port.
 */
`timescale 1ns/10ps
`default_nettype none
module test_adc_serial_control_frame;
    import adc_ctl_pkg::*;
    typedef struct packed {
        logic [7:0]  word;
        logic [11:0] res;
        logic        ext;
        logic [1:0]  tst;
    } row_s;
    // control word, result pushed after it, expected source decode
    localparam row_s ROWS [15] = '{
        '{8'h00, 12'h5a3, 1'b1, 2'h0}, '{8'h11, 12'h3c7, 1'b1, 2'h0},
        '{8'h2c, 12'h9e1, 1'b1, 2'h0}, '{8'h3e, 12'h0f0, 1'b1, 2'h0},
        '{8'h4c, 12'h7ff, 1'b1, 2'h0}, '{8'h54, 12'h800, 1'b1, 2'h0},
        '{8'h66, 12'h123, 1'b1, 2'h0}, '{8'h75, 12'ha55, 1'b1, 2'h0},
        '{8'h88, 12'h456, 1'b1, 2'h0}, '{8'h9a, 12'h321, 1'b1, 2'h0},
        '{8'ha0, 12'hfed, 1'b1, 2'h0}, '{8'hb1, 12'h0ab, 1'b0, 2'h1},
        '{8'hc0, 12'h111, 1'b0, 2'h2}, '{8'hd0, 12'hccc, 1'b0, 2'h3},
        '{8'he0, 12'h000, 1'b0, 2'h0}};

    logic        ref_clk   = 1'b0;
    logic        rst       = 1'b1;
    logic        res_valid = 1'b0;
    logic [11:0] res_data  = 12'h000;
    logic        io_clk, data_in, cs_n, data_out, data_out_oe, eoc, conv_start;
    logic        sample_active, power_down, conv_sel_ext, res_ready;
    logic [3:0]  conv_sel;
    logic [1:0]  conv_test_sel;
    logic [7:0]  pw;
    logic [11:0] pres;
    logic [15:0] got, smp;
    row_s        r;
    int          k;
    int          n_errors  = 0;
    int          cmp_count = 0;

    // 200 mhz clock
    always #2.5 ref_clk = ~ref_clk;

    adc_serial_control_frame i_dut (
        .ref_clk(ref_clk), .rst(rst), .io_clk(io_clk), .data_in(data_in), .cs_n(cs_n),
        .data_out(data_out), .data_out_oe(data_out_oe), .eoc(eoc), .conv_start(conv_start),
        .sample_active(sample_active), .power_down(power_down), .conv_sel(conv_sel),
        .conv_sel_ext(conv_sel_ext), .conv_test_sel(conv_test_sel),
        .res_valid(res_valid), .res_ready(res_ready), .res_data(res_data));

    host_port_model i_host (
        .ref_clk(ref_clk), .io_clk(io_clk), .data_in(data_in), .cs_n(cs_n),
        .data_out(data_out), .data_out_oe(data_out_oe), .sample_active(sample_active));

    task automatic check_val(input logic [15:0] g, input logic [15:0] e);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic report_and_stop;
        $display("errors=%0d compares=%0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    function automatic int len_of(input logic [7:0] w);
        return (w[3:2] == 2'b01) ? 8 : (w[3:2] == 2'b11) ? 16 : 12;
    endfunction

    // bits the host should read, first bit leftmost; order and sign come from the prior word
    function automatic logic [15:0] exp_out(input logic [7:0] w, input logic [11:0] d,
                                            input int n);
        logic [15:0] full, e;
        int          s, i;
        full = {d ^ {w[0], 11'h000}, 4'h0};
        s = 16 - len_of(w);
        e = 16'h0000;
        for (i = 0; i < n; i++)
            e = {e[14:0], w[1] ? full[s + i] : full[15 - i]};
        return e;
    endfunction

    // valid stays high on return; the caller lowers it
    task automatic push(input logic [11:0] d);
        int t;
        res_valid = 1'b1;
        res_data  = d;
        t = 0;
        while (res_ready !== 1'b1 && t < 200) begin
            @(negedge ref_clk);
            t++;
        end
        if (t >= 200)
            n_errors++;
        @(negedge ref_clk);
    endtask

    // one full i/o cycle and, when a conversion is due, its start
    task automatic run(input logic [7:0] w, input logic chk, input logic [15:0] e,
                       input logic conv);
        int n, t;
        n = len_of(w);
        t = 0;
        while (eoc !== 1'b1 && t < 2000) begin
            @(negedge ref_clk);
            t++;
        end
        check_val(16'(eoc), 16'h0001);
        i_host.frame(w, n, 99, got, smp);
        if (chk)
            check_val(got, e);
        t = 0;
        while (conv_start !== 1'b1 && t < 60) begin
            @(negedge ref_clk);
            t++;
        end
        if (conv) begin
            check_val(16'(t >= EOC_DLY_CYC && t <= EOC_DLY_CYC + 8), 16'h0001);
            check_val(16'({data_out_oe, eoc, sample_active, conv_sel}), 16'({3'b100, w[7:4]}));
            check_val(smp, 16'((1 << (n - 4)) - 1));
        end else
            check_val(16'(t), 16'd60);
        check_val(16'(power_down), 16'(w[7:4] == ADDR_PDOWN));
    endtask

    // watchdog sized well above the expected run of about 55 us
    initial begin
        #400000;
        n_errors++;
        report_and_stop();
    end

    initial begin
        repeat (10) @(negedge ref_clk);
        rst = 1'b0;
        @(negedge ref_clk);
        check_val(16'({eoc, power_down, data_out_oe, conv_start, sample_active, res_ready}),
                  16'h0031);
        // table: address codes 0 to 14, every length code, both orders and formats
        pw = 8'h00;
        pres = 12'h000;
        for (k = 0; k < 15; k++) begin
            r = ROWS[k];
            run(r.word, k > 0, exp_out(pw, pres, len_of(r.word)), r.word[7:4] != ADDR_PDOWN);
            if (r.word[7:4] != ADDR_PDOWN) begin
                check_val(16'({conv_sel_ext, conv_test_sel}), 16'({r.ext, r.tst}));
                push(r.res);
                res_valid = 1'b0;
            end
            pw = r.word;
            pres = r.res;
        end
        // no conversion pending, so results pile up until the buffer refuses
        for (k = 0; k < 16; k++)
            push(12'h100 + 12'(k));
        res_valid = 1'b0;
        @(negedge ref_clk);
        check_val(16'({res_ready, eoc}), 16'h0001);
        // select dropped before the fourth fall: no wake-up, output released
        i_host.frame(8'h0c, 12, 3, got, smp);
        repeat (8) @(negedge ref_clk);
        check_val(16'({data_out_oe, eoc, power_down}), 16'h0003);
        // each conversion drains one stored result; the last one finds it empty
        for (k = 0; k < 17; k++)
            run(8'h00, k > 0, exp_out(8'h00, 12'h100 + 12'(k - 1), 12), 1'b1);
        check_val(16'({res_ready, eoc}), 16'h0002);
        report_and_stop();
    end
endmodule
`default_nettype wire
